// ==== verilog/eerap_slave.sv ====
`default_nettype none
module eerap_slave
    import eerap_pkg::*;
#(
    parameter int WR_CYC = EERAP_WR_CYC
)(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Two-wire bus; sda_oe_n low drives the line low
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    // Select pins
    input  wire logic        select_pin_bit0,
    input  wire logic        select_pin_bit1,
    input  wire logic        select_pin_bit2,
    // Memory array port, data taken in the same cycle as the request
    output eerap_mem_req_type mem_req,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    // Status
    output logic             wr_busy,
    output logic [7:0]       addr_ptr
);
    eerap_bus_ev_type ev;
    eerap_state_type  st_q, st_d;
    logic [7:0]  sh_q, sh_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        dir_q, dir_d;
    logic        ackok_q, ackok_d;
    logic        wdat_q, wdat_d;
    logic        arm_q, arm_d;
    logic        oe_n_q, oe_n_d;
    logic        busy_q;
    logic [31:0] wcnt_q;
    logic        rd_q, rd_d;
    logic        load_q, load_d;
    logic        go_q, go_d;
    logic [7:0]  wd_q, wd_d;
    logic [2:0]  sel_s1_q, sel_s2_q;

    eerap_bus_sync u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .ev      (ev)
    );

    // Select pins are straps from outside, synchronised too
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_s1_q <= 3'h0;
            sel_s2_q <= 3'h0;
        end else begin
            sel_s1_q <= {select_pin_bit2, select_pin_bit1, select_pin_bit0};
            sel_s2_q <= sel_s1_q;
        end
    end

    // Control byte decode on the assembled shift value
    wire       byte_done = ev.fall && (bit_q == 4'h8);
    wire       typ_ok    = sh_q[7:EERAP_CTL_TYP_LO] == EERAP_TYPE_CODE;
    wire       sel_ok    = sh_q[EERAP_CTL_TYP_LO-1:EERAP_CTL_SEL_LO] == sel_s2_q;
    wire       match     = typ_ok && sel_ok && !busy_q;
    wire       is_read   = sh_q[EERAP_CTL_DIR];
    wire [7:0] ptr_inc   = ptr_q + 8'h01;

    // Protocol engine
    always_comb begin
        st_d    = st_q;
        sh_d    = sh_q;
        bit_d   = bit_q;
        ptr_d   = ptr_q;
        dir_d   = dir_q;
        ackok_d = ackok_q;
        wdat_d  = wdat_q;
        arm_d   = arm_q;
        oe_n_d  = oe_n_q;
        rd_d    = 1'b0;
        load_d  = load_q;
        go_d    = 1'b0;
        wd_d    = wd_q;
        if (load_q) begin
            sh_d   = mem_rdata;
            load_d = 1'b0;
        end
        if (ev.stop) begin
            // Write committed only when a data byte arrived
            go_d   = arm_q;
            arm_d  = 1'b0;
            st_d   = EERAP_IDLE;
            oe_n_d = 1'b1;
        end else if (ev.start) begin
            // Repeated start abandons a write after the pointer was set
            arm_d  = 1'b0;
            st_d   = EERAP_CTL;
            bit_d  = 4'h0;
            oe_n_d = 1'b1;
        end else begin
            unique case (st_q)
                EERAP_IDLE: begin
                    oe_n_d = 1'b1;
                end
                EERAP_CTL, EERAP_WADR, EERAP_WDAT: begin
                    if (ev.rise && bit_q != 4'h8) begin
                        sh_d  = {sh_q[6:0], ev.sda};
                        bit_d = bit_q + 4'h1;
                    end
                    if (byte_done) begin
                        bit_d = 4'h0;
                        if (st_q == EERAP_CTL) begin
                            ackok_d = match;
                            dir_d   = is_read;
                            oe_n_d  = !match;
                            if (!match) st_d = EERAP_IDLE;
                            else        st_d = EERAP_AACK;
                        end else if (st_q == EERAP_WADR) begin
                            ptr_d   = sh_q;
                            oe_n_d  = 1'b0;
                            wdat_d  = 1'b1;
                            st_d    = EERAP_AACK;
                        end else begin
                            wd_d    = sh_q;
                            arm_d   = 1'b1;
                            ptr_d   = {ptr_q[7:4], ptr_q[3:0] + 4'h1};
                            oe_n_d  = 1'b0;
                            st_d    = EERAP_AACK;
                        end
                    end
                end
                EERAP_AACK: begin
                    // Acknowledge slot ends on the next falling clock
                    if (ev.fall) begin
                        if (dir_q && ackok_q) begin
                            rd_d   = 1'b1;
                            load_d = 1'b1;
                            ptr_d  = ptr_inc;
                            st_d   = EERAP_TX;
                            oe_n_d = 1'b1;
                        end else begin
                            oe_n_d = 1'b1;
                            st_d   = wdat_q ? EERAP_WDAT : EERAP_WADR;
                        end
                        ackok_d = 1'b0;
                    end
                end
                EERAP_TX: begin
                    // Drive low only for zero bits, released for ones
                    if (!load_q) oe_n_d = sh_q[7];
                    if (ev.fall) begin
                        sh_d  = {sh_q[6:0], 1'b1};
                        bit_d = bit_q + 4'h1;
                        if (bit_q == 4'h7) begin
                            oe_n_d = 1'b1;
                            st_d   = EERAP_MACK;
                            bit_d  = 4'h0;
                        end
                    end
                end
                EERAP_MACK: begin
                    oe_n_d = 1'b1;
                    if (ev.rise) begin
                        ackok_d = !ev.sda;
                    end
                    if (ev.fall) begin
                        if (ackok_q) begin
                            rd_d   = 1'b1;
                            load_d = 1'b1;
                            ptr_d  = ptr_inc;
                            st_d   = EERAP_TX;
                        end else begin
                            st_d   = EERAP_IDLE;
                        end
                        ackok_d = 1'b0;
                    end
                end
                default: begin
                    st_d   = EERAP_IDLE;
                    oe_n_d = 1'b1;
                end
            endcase
        end
        // Fresh control byte clears the write-phase marker
        if (ev.start) wdat_d = 1'b0;
    end

    // State registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q    <= EERAP_IDLE;
            sh_q    <= 8'h00;
            bit_q   <= 4'h0;
            ptr_q   <= EERAP_ADDR_RST;
            dir_q   <= 1'b0;
            ackok_q <= 1'b0;
            wdat_q  <= 1'b0;
            arm_q   <= 1'b0;
            oe_n_q  <= 1'b1;
            rd_q    <= 1'b0;
            load_q  <= 1'b0;
            go_q    <= 1'b0;
            wd_q    <= 8'h00;
        end else begin
            st_q    <= st_d;
            sh_q    <= sh_d;
            bit_q   <= bit_d;
            ptr_q   <= ptr_d;
            dir_q   <= dir_d;
            ackok_q <= ackok_d;
            wdat_q  <= wdat_d;
            arm_q   <= arm_d;
            oe_n_q  <= oe_n_d;
            rd_q    <= rd_d;
            load_q  <= load_d;
            go_q    <= go_d;
            wd_q    <= wd_d;
        end
    end

    // Self-timed write cycle; counter is long, hence the parameter
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            wcnt_q <= 32'h0;
        end else if (go_d) begin
            busy_q <= 1'b1;
            wcnt_q <= 32'(WR_CYC - 1);
        end else if (busy_q) begin
            if (wcnt_q == 32'h0) busy_q <= 1'b0;
            else wcnt_q <= wcnt_q - 32'h1;
        end
    end

    // Output flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_req <= '0;
            wr_busy <= 1'b0;
        end else begin
            mem_req.rd    <= rd_d;
            mem_req.wr_go <= go_d;
            mem_req.addr  <= rd_d ? ptr_q : ptr_d;
            wr_busy       <= busy_q | go_d;
        end
    end

    assign sda_out   = 1'b0;
    assign sda_oe_n  = oe_n_q;
    assign mem_wdata = wd_q;
    assign addr_ptr  = ptr_q;
endmodule : eerap_slave
`default_nettype wire

// ==== include/eerap_pkg.sv ====
`default_nettype none
package eerap_pkg;
    // Device-type code; value is arbitrary
    localparam logic [3:0] EERAP_TYPE_CODE  = 4'h5;
    // Address and data widths
    localparam int         EERAP_ADDR_W     = 8;
    localparam int         EERAP_DATA_W     = 8;
    localparam logic [7:0] EERAP_ADDR_RST   = 8'h00;
    localparam logic [7:0] EERAP_ADDR_TOP   = 8'hff;
    // Control byte fields
    localparam int         EERAP_CTL_DIR    = 0;
    localparam int         EERAP_CTL_SEL_LO = 1;
    localparam int         EERAP_CTL_TYP_LO = 4;
    // Internal write cycle time, in ns, and its count at 200 MHz
    localparam int         EERAP_CLK_NS     = 5;
    localparam int         EERAP_WR_NS      = 5000000;
    localparam int         EERAP_WR_CYC     = EERAP_WR_NS / EERAP_CLK_NS;

    // Bus conditions found by the edge finder
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } eerap_bus_ev_type;

    // Memory port toward the array
    typedef struct packed {
        logic       rd;
        logic       wr_go;
        logic [7:0] addr;
    } eerap_mem_req_type;

    typedef enum logic [6:0] {
        EERAP_IDLE = 7'h01,
        EERAP_CTL  = 7'h02,
        EERAP_AACK = 7'h04,
        EERAP_WADR = 7'h08,
        EERAP_WDAT = 7'h10,
        EERAP_TX   = 7'h20,
        EERAP_MACK = 7'h40
    } eerap_state_type;
endpackage : eerap_pkg
`default_nettype wire

// ==== verilog/eerap_bus_sync.sv ====
`default_nettype none
// Pin synchroniser and bus condition finder
module eerap_bus_sync
    import eerap_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    // Events
    output eerap_bus_ev_type ev
);
    logic [1:0] scl_s1_q;
    logic [1:0] scl_s2_q;
    logic [1:0] sda_s1_q;
    logic [1:0] sda_s2_q;

    // Three flops per pin, then one history stage for edges
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scl_s1_q <= 2'h3;
            scl_s2_q <= 2'h3;
            sda_s1_q <= 2'h3;
            sda_s2_q <= 2'h3;
        end else begin
            scl_s1_q <= {scl_s1_q[0], scl_in};
            sda_s1_q <= {sda_s1_q[0], sda_in};
            scl_s2_q <= {scl_s2_q[0], scl_s1_q[1]};
            sda_s2_q <= {sda_s2_q[0], sda_s1_q[1]};
        end
    end

    // Data edges while clock high mark start and stop
    assign ev.start = scl_s2_q[0] & scl_s2_q[1] & sda_s2_q[1] & ~sda_s2_q[0];
    assign ev.stop  = scl_s2_q[0] & scl_s2_q[1] & ~sda_s2_q[1] & sda_s2_q[0];
    assign ev.rise  = scl_s2_q[0] & ~scl_s2_q[1];
    assign ev.fall  = ~scl_s2_q[0] & scl_s2_q[1];
    assign ev.sda   = sda_s2_q[0];
endmodule : eerap_bus_sync
`default_nettype wire

// ==== sim/eerap_slave_props.sv ====
`default_nettype none
// Timing checks on the slave's pins and status
module eerap_slave_props
    import eerap_pkg::*;
#(
    parameter int WR_CYC = EERAP_WR_CYC
)(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              arst_n,
    // Bus and straps
    input wire logic              scl_in,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe_n,
    input wire logic              select_pin_bit0,
    input wire logic              select_pin_bit1,
    input wire logic              select_pin_bit2,
    // Array port and status
    input wire eerap_mem_req_type mem_req,
    input wire logic [7:0]        mem_wdata,
    input wire logic [7:0]        mem_rdata,
    input wire logic              wr_busy,
    input wire logic [7:0]        addr_ptr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    int         busy_cnt_q;
    logic [7:0] rd_addr_q;
    // Busy length and last fetched address; a delay range cannot span the write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt_q <= 0;
            rd_addr_q  <= 8'h00;
        end else begin
            busy_cnt_q <= wr_busy ? busy_cnt_q + 1 : 0;
            if (mem_req.rd) begin
                rd_addr_q <= mem_req.addr;
            end
        end
    end
    // A pull seen at a clock rise must stand for the next 8 cycles of the high phase
    AST_ACK_PULLS_LOW: assert property ($rose(scl_in) && !sda_oe_n |=>
        (!sda_oe_n && !sda_out) [*8])
        else $error("drive dropped while clock high");
    AST_FETCH_AT_PTR: assert property (mem_req.rd |-> mem_req.addr == $past(addr_ptr))
        else $error("fetch address is not the pointer");
    AST_QUIET_WHILE_BUSY: assert property (wr_busy |-> sda_oe_n)
        else $error("line driven during write cycle");
    AST_GO_AT_STOP: assert property (mem_req.wr_go |-> scl_in && sda_in)
        else $error("write started away from a stop");
    AST_BUSY_FOLLOWS_GO: assert property (mem_req.wr_go |-> ##[1:3] wr_busy)
        else $error("write cycle not begun");
    AST_BUSY_LENGTH: assert property ($fell(wr_busy) |->
        busy_cnt_q >= WR_CYC - 1 && busy_cnt_q <= WR_CYC + 1)
        else $error("write cycle length wrong");
    AST_PTR_STEP: assert property (mem_req.rd |=> ##[0:1] addr_ptr == rd_addr_q + 8'h01)
        else $error("pointer not one past fetched byte");
    AST_FETCH_PULSE: assert property (mem_req.rd |=> !mem_req.rd)
        else $error("fetch strobe longer than a cycle");
    AST_STILL_SCL_HIGH: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data line changed with clock high");
    AST_RELEASE_AT_STOP: assert property (scl_in && $rose(sda_in) |=> sda_oe_n [*8])
        else $error("line driven after stop");
endmodule : eerap_slave_props
bind eerap_slave eerap_slave_props #(.WR_CYC(WR_CYC)) u_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .select_pin_bit0(select_pin_bit0),
    .select_pin_bit1(select_pin_bit1), .select_pin_bit2(select_pin_bit2),
    .mem_req(mem_req), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .wr_busy(wr_busy), .addr_ptr(addr_ptr));
`default_nettype wire

// ==== sim/eerap_mst_model.sv ====
`default_nettype none
// Bus master; its clock stands still between frames
module eerap_mst_model (
    // Clock
    input  wire logic clk_sys,
    // Bus
    input  wire logic sda_in,
    output var  logic scl,
    output var  logic sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus, both lines released
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wt
    // Start, or repeated start from a low clock
    task automatic start();
        sda_drv = 1'b1;
        wt(6);
        scl = 1'b1;
        wt(6);
        sda_drv = 1'b0;
        wt(6);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        wt(6);
        sda_drv = 1'b0;
        wt(6);
        scl = 1'b1;
        wt(6);
        sda_drv = 1'b1;
        wt(12);
    endtask : stop
    // One 125 ns bit, sampled mid-high
    task automatic bitx(input logic b, output logic r);
        wt(6);
        sda_drv = b;
        wt(6);
        scl = 1'b1;
        wt(6);
        r = sda_in;
        wt(7);
        scl = 1'b0;
    endtask : bitx
    // Byte MSB first, then the ack slot
    task automatic byte_x(input logic [7:0] d, input logic a_in,
                          output logic [7:0] q, output logic a_out);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(a_in, a_out);
    endtask : byte_x
    task automatic ctl(input logic [7:0] c, output logic ack);
        logic [7:0] q;
        start();
        byte_x(c, 1'b1, q, ack);
    endtask : ctl
endmodule : eerap_mst_model
`default_nettype wire

// ==== sim/testbench.sv ====
`default_nettype none
module testbench
    import eerap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Short write cycle so polling is refused a few times
    localparam int     WR_CYC = 600;
    logic              clk_sys = 1'b0;
    logic              arst_n  = 1'b0;
    logic [2:0]        sel     = 3'h5;
    logic              scl, sda_m, sda_w, sda_out, sda_oe_n, wr_busy;
    logic [7:0]        mem_wdata, mem_rdata, addr_ptr;
    eerap_mem_req_type mem_req;
    int                fails = 0, checks_done = 0, cycles = 0;
    // Pulled-up wire; array returns a pattern of its address
    assign sda_w     = sda_m & (sda_oe_n | sda_out);
    assign mem_rdata = mem_req.addr ^ 8'h3c;
    always #2.5 clk_sys = ~clk_sys;
    eerap_slave #(.WR_CYC(WR_CYC)) u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .select_pin_bit0(sel[0]),
        .select_pin_bit1(sel[1]), .select_pin_bit2(sel[2]), .mem_req(mem_req),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wr_busy(wr_busy),
        .addr_ptr(addr_ptr));
    eerap_mst_model u_mst (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl), .sda_drv(sda_m));
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] cb(input logic dir);
        return {EERAP_TYPE_CODE, sel, dir};
    endfunction : cb
    // Random read at fe, then on across the top
    task automatic t_seq_read();
        logic       ak;
        logic [7:0] q;
        u_mst.ctl(cb(1'b0), ak);
        chk("ctl ack", ak, 8'h00);
        u_mst.byte_x(8'hfe, 1'b1, q, ak);
        chk("addr ack", ak, 8'h00);
        u_mst.ctl(cb(1'b1), ak);
        chk("read ack", ak, 8'h00);
        for (int i = 0; i < 3; i++) begin
            u_mst.byte_x(8'hff, i == 2, q, ak);
            chk("seq data", q, (8'hfe + 8'(i)) ^ 8'h3c);
        end
        chk("nack release", ak, 8'h01);
        u_mst.stop();
        chk("ptr after read", addr_ptr, 8'h01);
    endtask : t_seq_read
    task automatic t_cur_read(input logic [7:0] a);
        logic       ak;
        logic [7:0] q;
        u_mst.ctl(cb(1'b1), ak);
        chk("cur ack", ak, 8'h00);
        u_mst.byte_x(8'hff, 1'b1, q, ak);
        chk("cur data", q, a ^ 8'h3c);
        u_mst.stop();
        chk("released", sda_oe_n, 8'h01);
        chk("ptr step", addr_ptr, a + 8'h01);
    endtask : t_cur_read
    // Foreign type code and select bits must be ignored
    task automatic t_mismatch();
        logic ak;
        sel = 3'h2;
        u_mst.ctl({EERAP_TYPE_CODE ^ 4'h3, sel, 1'b1}, ak);
        u_mst.stop();
        chk("type nack", ak, 8'h01);
        u_mst.ctl({EERAP_TYPE_CODE, ~sel, 1'b1}, ak);
        u_mst.stop();
        chk("select nack", ak, 8'h01);
        t_cur_read(8'h02);
    endtask : t_mismatch
    // Byte write, then poll until acknowledged
    task automatic t_write_poll();
        int         polls;
        logic       ak;
        logic [7:0] q;
        u_mst.ctl(cb(1'b0), ak);
        u_mst.byte_x(8'h10, 1'b1, q, ak);
        u_mst.byte_x(8'ha5, 1'b1, q, ak);
        u_mst.stop();
        chk("busy", wr_busy, 8'h01);
        chk("wdata", mem_wdata, 8'ha5);
        polls = 0;
        ak = 1'b1;
        while (ak === 1'b1 && polls < 20) begin
            u_mst.ctl(cb(1'b0), ak);
            polls++;
        end
        // A poll that never gets through must not look like success
        chk("poll ack", ak, 8'h00);
        u_mst.stop();
        chk("polls refused", 8'(polls > 1), 8'h01);
        chk("idle at ack", wr_busy, 8'h00);
        t_cur_read(8'h11);
    endtask : t_write_poll
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (8) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        t_seq_read();
        t_cur_read(8'h01);
        t_mismatch();
        t_write_poll();
        print_verdict();
    end
    // Hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
endmodule : testbench
`default_nettype wire
